// ---- verilog/cwtc_pkg.sv ----
// Constants for the channel 1 window threshold configuration bank.
// Notes on behaviour
// - The fast overvoltage limit is an 8-bit read/write register that resets to all ones.
// - With the range scaling bit clear a code means 200 mV plus 5 mV per step.
// - With the range scaling bit set a code means 800 mV plus 20 mV per step.
// - The slow undervoltage limit is an 8-bit read/write register that resets to zero.
// - The slow overvoltage limit is an 8-bit read/write register that resets to all ones.
// - The upper nibble of the debounce register sets how long an overvoltage must last.
// - Debounce codes give 0.1 us doubled per step up to 51.2 us, and 102.4 us from ten on.
// - The lower nibble sets the undervoltage debounce the same way, and both reset to zero.
// - The cutoff register sets the slow low-pass corner, its upper five bits are spare.
// - Cutoff codes two to six give 250 Hz to 4 kHz, and codes 0, 1 and 7 are invalid.
// - The range scaling bit selects 1x when clear and 4x when set for every threshold.
package cwtc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_FAST_OVER = 8'h21;
    localparam logic [7:0] ADDR_SLOW_UNDER = 8'h22;
    localparam logic [7:0] ADDR_SLOW_OVER = 8'h23;
    localparam logic [7:0] ADDR_FAST_DEB = 8'h24;
    localparam logic [7:0] ADDR_SLOW_CUT = 8'h25;
    localparam logic [7:0] RST_FAST_OVER = 8'hFF;
    localparam logic [7:0] RST_SLOW_UNDER = 8'h00;
    localparam logic [7:0] RST_SLOW_OVER = 8'hFF;
    localparam logic [7:0] RST_FAST_DEB = 8'h00;
    localparam logic [7:0] RST_SLOW_CUT = 8'h04;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    localparam int OVER_DEB_LSB = 4;
    localparam int UNDER_DEB_LSB = 0;
    localparam int DEB_W = 4;
    localparam int CUT_LSB = 0;
    localparam int CUT_W = 3;
    // ----------------------------------------------------------------
    // Threshold scaling in millivolts
    // ----------------------------------------------------------------
    localparam int MV_W = 13;
    localparam logic [MV_W-1:0] LO_BASE_MV = 13'h00C8;
    localparam logic [MV_W-1:0] LO_STEP_MV = 13'h0005;
    localparam logic [MV_W-1:0] HI_BASE_MV = 13'h0320;
    localparam logic [MV_W-1:0] HI_STEP_MV = 13'h0014;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_NS = 10;
    localparam int DEB_BASE_NS = 100;
    localparam int DEB_UNIT_CYC = (DEB_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEB_CODE_CAP = 10;
    localparam int DEB_MAX_CYC = DEB_UNIT_CYC << DEB_CODE_CAP;
    // Low-pass: y += (x - y) / 2^LPF_SHIFT per tick, corner = f_tick / (2 pi 2^LPF_SHIFT).
    localparam int LPF_SHIFT = 4;
    localparam int LPF_K10 = 1005;
    localparam int CUT_250_HZ = 250;
    localparam int CUT_500_HZ = 500;
    localparam int CUT_1K_HZ = 1000;
    localparam int CUT_2K_HZ = 2000;
    localparam int CUT_4K_HZ = 4000;
    localparam int DIV_250 = (CLK_HZ / CUT_250_HZ) * 10 / LPF_K10;
    localparam int DIV_500 = (CLK_HZ / CUT_500_HZ) * 10 / LPF_K10;
    localparam int DIV_1K = (CLK_HZ / CUT_1K_HZ) * 10 / LPF_K10;
    localparam int DIV_2K = (CLK_HZ / CUT_2K_HZ) * 10 / LPF_K10;
    localparam int DIV_4K = (CLK_HZ / CUT_4K_HZ) * 10 / LPF_K10;
    localparam int DIV_W = 12;
    localparam logic [CUT_W-1:0] CODE_250 = 3'h2;
    localparam logic [CUT_W-1:0] CODE_500 = 3'h3;
    localparam logic [CUT_W-1:0] CODE_1K = 3'h4;
    localparam logic [CUT_W-1:0] CODE_2K = 3'h5;
    localparam logic [CUT_W-1:0] CODE_4K = 3'h6;
endpackage

// ---- verilog/cwtc_debounce.sv ----
// Comparator debounce: the output follows the input once it has held for the selected time.
`timescale 1ns/1ns
module cwtc_debounce #(
    parameter int P_MAX_CYC = cwtc_pkg::DEB_MAX_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_raw,
    input wire logic [cwtc_pkg::DEB_W-1:0] i_code,
    output logic o_level
);
    localparam int CNT_W = $clog2(P_MAX_CYC + 1);
    localparam int UNIT = P_MAX_CYC >> cwtc_pkg::DEB_CODE_CAP;

    if (UNIT < 1) begin
        $error("cwtc_debounce: P_MAX_CYC too small");
    end

    // ----------------------------------------------------------------
    // Code to cycle count
    // ----------------------------------------------------------------
    function automatic logic [CNT_W-1:0] deb_cycles(input logic [cwtc_pkg::DEB_W-1:0] code);
        int sh;
        sh = (int'(code) > cwtc_pkg::DEB_CODE_CAP) ? cwtc_pkg::DEB_CODE_CAP : int'(code);
        return CNT_W'(UNIT << sh);
    endfunction

    logic level_r;
    logic level_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] limit;

    always_comb begin
        limit = deb_cycles(i_code);
        level_nxt = level_r;
        cnt_nxt = '0;
        if (i_raw != level_r) begin
            if (cnt_r + CNT_W'(1) >= limit) begin
                level_nxt = i_raw;
            end else begin
                cnt_nxt = cnt_r + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            level_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            level_r <= level_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign o_level = level_r;
endmodule

// ---- verilog/cwtc_top.sv ----
// Channel 1 threshold registers with the fault comparators that consume them.
`timescale 1ns/1ns
module cwtc_top #(
    parameter int P_DEB_MAX_CYC = cwtc_pkg::DEB_MAX_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_range_scaling_bit,
    input wire logic [7:0] i_fast_under_limit,
    input wire logic [cwtc_pkg::MV_W-1:0] i_vmon_mv,
    output logic [cwtc_pkg::MV_W-1:0] o_slow_vmon_mv,
    output logic o_fast_over_fault,
    output logic o_fast_under_fault,
    output logic o_slow_over_fault,
    output logic o_slow_under_fault,
    output logic o_cut_invalid
);
    localparam int MV_W = cwtc_pkg::MV_W;
    localparam int ACC_W = MV_W + cwtc_pkg::LPF_SHIFT;

    // A debounce unit below one cycle cannot be counted, so such a build is refused.
    if (P_DEB_MAX_CYC < (1 << cwtc_pkg::DEB_CODE_CAP)) begin
        $error("cwtc_top: P_DEB_MAX_CYC must be at least 1024");
    end

    // ----------------------------------------------------------------
    // Threshold decode
    // ----------------------------------------------------------------
    function automatic logic [MV_W-1:0] thr_mv(input logic [7:0] code, input logic x4);
        logic [MV_W-1:0] c;
        c = {{(MV_W-8){1'b0}}, code};
        if (x4) begin
            return MV_W'(cwtc_pkg::HI_BASE_MV + c * cwtc_pkg::HI_STEP_MV);
        end
        return MV_W'(cwtc_pkg::LO_BASE_MV + c * cwtc_pkg::LO_STEP_MV);
    endfunction

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    logic [7:0] fast_over_limit_r;
    logic [7:0] fast_over_limit_nxt;
    logic [7:0] slow_under_limit_r;
    logic [7:0] slow_under_limit_nxt;
    logic [7:0] slow_over_limit_r;
    logic [7:0] slow_over_limit_nxt;
    logic [7:0] fast_debounce_select_r;
    logic [7:0] fast_debounce_select_nxt;
    logic [7:0] slow_cutoff_select_r;
    logic [7:0] slow_cutoff_select_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb begin
        fast_over_limit_nxt = fast_over_limit_r;
        slow_under_limit_nxt = slow_under_limit_r;
        slow_over_limit_nxt = slow_over_limit_r;
        fast_debounce_select_nxt = fast_debounce_select_r;
        slow_cutoff_select_nxt = slow_cutoff_select_r;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                cwtc_pkg::ADDR_FAST_OVER: fast_over_limit_nxt = i_reg_wdata;
                cwtc_pkg::ADDR_SLOW_UNDER: slow_under_limit_nxt = i_reg_wdata;
                cwtc_pkg::ADDR_SLOW_OVER: slow_over_limit_nxt = i_reg_wdata;
                cwtc_pkg::ADDR_FAST_DEB: fast_debounce_select_nxt = i_reg_wdata;
                cwtc_pkg::ADDR_SLOW_CUT: slow_cutoff_select_nxt = i_reg_wdata;
                default: begin
                end
            endcase
        end
        unique case (i_reg_addr)
            cwtc_pkg::ADDR_FAST_OVER: rdata_nxt = fast_over_limit_r;
            cwtc_pkg::ADDR_SLOW_UNDER: rdata_nxt = slow_under_limit_r;
            cwtc_pkg::ADDR_SLOW_OVER: rdata_nxt = slow_over_limit_r;
            cwtc_pkg::ADDR_FAST_DEB: rdata_nxt = fast_debounce_select_r;
            cwtc_pkg::ADDR_SLOW_CUT: rdata_nxt = slow_cutoff_select_r;
            default: rdata_nxt = cwtc_pkg::RDATA_UNMAPPED;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            fast_over_limit_r <= cwtc_pkg::RST_FAST_OVER;
            slow_under_limit_r <= cwtc_pkg::RST_SLOW_UNDER;
            slow_over_limit_r <= cwtc_pkg::RST_SLOW_OVER;
            fast_debounce_select_r <= cwtc_pkg::RST_FAST_DEB;
            slow_cutoff_select_r <= cwtc_pkg::RST_SLOW_CUT;
            rdata_r <= cwtc_pkg::RDATA_UNMAPPED;
        end else begin
            fast_over_limit_r <= fast_over_limit_nxt;
            slow_under_limit_r <= slow_under_limit_nxt;
            slow_over_limit_r <= slow_over_limit_nxt;
            fast_debounce_select_r <= fast_debounce_select_nxt;
            slow_cutoff_select_r <= slow_cutoff_select_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // Fast path comparators and debounce
    // ----------------------------------------------------------------
    logic [MV_W-1:0] fast_over_mv;
    logic [MV_W-1:0] fast_under_mv;
    logic [MV_W-1:0] slow_over_mv;
    logic [MV_W-1:0] slow_under_mv;
    logic fast_over_raw_r;
    logic fast_over_raw_nxt;
    logic fast_under_raw_r;
    logic fast_under_raw_nxt;
    logic [cwtc_pkg::DEB_W-1:0] over_debounce_code;
    logic [cwtc_pkg::DEB_W-1:0] under_debounce_code;

    // The scaling bit applies to every threshold of the channel.
    always_comb begin
        fast_over_mv = thr_mv(fast_over_limit_r, i_range_scaling_bit);
        fast_under_mv = thr_mv(i_fast_under_limit, i_range_scaling_bit);
        slow_over_mv = thr_mv(slow_over_limit_r, i_range_scaling_bit);
        slow_under_mv = thr_mv(slow_under_limit_r, i_range_scaling_bit);
        fast_over_raw_nxt = i_vmon_mv > fast_over_mv;
        fast_under_raw_nxt = i_vmon_mv < fast_under_mv;
        over_debounce_code = fast_debounce_select_r[cwtc_pkg::OVER_DEB_LSB +: cwtc_pkg::DEB_W];
        under_debounce_code = fast_debounce_select_r[cwtc_pkg::UNDER_DEB_LSB +: cwtc_pkg::DEB_W];
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            fast_over_raw_r <= 1'b0;
            fast_under_raw_r <= 1'b0;
        end else begin
            fast_over_raw_r <= fast_over_raw_nxt;
            fast_under_raw_r <= fast_under_raw_nxt;
        end
    end

    cwtc_debounce #(
        .P_MAX_CYC(P_DEB_MAX_CYC)
    ) u_over_deb (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_raw(fast_over_raw_r),
        .i_code(over_debounce_code),
        .o_level(o_fast_over_fault)
    );

    cwtc_debounce #(
        .P_MAX_CYC(P_DEB_MAX_CYC)
    ) u_under_deb (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_raw(fast_under_raw_r),
        .i_code(under_debounce_code),
        .o_level(o_fast_under_fault)
    );

    // ----------------------------------------------------------------
    // Slow path low-pass filter
    // ----------------------------------------------------------------
    localparam int CUT_W_L = cwtc_pkg::CUT_W;
    logic [CUT_W_L-1:0] cut_code;
    logic [cwtc_pkg::DIV_W-1:0] div_limit;
    logic cut_valid;
    logic [cwtc_pkg::DIV_W-1:0] div_r;
    logic [cwtc_pkg::DIV_W-1:0] div_nxt;
    logic tick;
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic signed [ACC_W+1:0] diff;
    logic slow_over_r;
    logic slow_over_nxt;
    logic slow_under_r;
    logic slow_under_nxt;
    logic [MV_W-1:0] slow_mv;

    // Invalid cutoff codes freeze the filter rather than guess a corner.
    always_comb begin
        cut_code = slow_cutoff_select_r[cwtc_pkg::CUT_LSB +: CUT_W_L];
        cut_valid = 1'b1;
        unique case (cut_code)
            cwtc_pkg::CODE_250: div_limit = cwtc_pkg::DIV_W'(cwtc_pkg::DIV_250);
            cwtc_pkg::CODE_500: div_limit = cwtc_pkg::DIV_W'(cwtc_pkg::DIV_500);
            cwtc_pkg::CODE_1K: div_limit = cwtc_pkg::DIV_W'(cwtc_pkg::DIV_1K);
            cwtc_pkg::CODE_2K: div_limit = cwtc_pkg::DIV_W'(cwtc_pkg::DIV_2K);
            cwtc_pkg::CODE_4K: div_limit = cwtc_pkg::DIV_W'(cwtc_pkg::DIV_4K);
            default: begin
                div_limit = cwtc_pkg::DIV_W'(cwtc_pkg::DIV_1K);
                cut_valid = 1'b0;
            end
        endcase
        tick = cut_valid && (div_r >= div_limit - cwtc_pkg::DIV_W'(1));
        div_nxt = (tick || !cut_valid) ? '0 : div_r + cwtc_pkg::DIV_W'(1);
        diff = $signed({2'b00, i_vmon_mv, {cwtc_pkg::LPF_SHIFT{1'b0}}})
            - $signed({2'b00, acc_r});
        acc_nxt = tick ? ACC_W'($signed({2'b00, acc_r}) + (diff >>> cwtc_pkg::LPF_SHIFT))
            : acc_r;
        slow_mv = acc_r[ACC_W-1 -: MV_W];
        slow_over_nxt = slow_mv > slow_over_mv;
        slow_under_nxt = slow_mv < slow_under_mv;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            div_r <= '0;
            acc_r <= '0;
            slow_over_r <= 1'b0;
            slow_under_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            acc_r <= acc_nxt;
            slow_over_r <= slow_over_nxt;
            slow_under_r <= slow_under_nxt;
        end
    end

    assign o_slow_vmon_mv = slow_mv;
    assign o_slow_over_fault = slow_over_r;
    assign o_slow_under_fault = slow_under_r;
    assign o_cut_invalid = !cut_valid;
endmodule

// ---- sim/cwtc_chk.sv ----
// Concurrent checks on the channel 1 threshold bank ports.
`timescale 1ns/1ns
module cwtc_chk #(
    parameter int P_DEB_MAX_CYC = 10240
) (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_range_scaling_bit,
    input wire logic [7:0] i_fast_under_limit,
    input wire logic [12:0] i_vmon_mv,
    input wire logic [12:0] o_slow_vmon_mv,
    input wire logic o_fast_over_fault,
    input wire logic o_fast_under_fault,
    input wire logic o_slow_over_fault,
    input wire logic o_slow_under_fault,
    input wire logic o_cut_invalid
);
    localparam int UNIT = P_DEB_MAX_CYC >> 10;
    logic [7:0] sh_r [5];
    logic [7:0] sh_nxt [5];
    logic ov_now;
    logic uv_now;
    function automatic logic [12:0] to_mv(input logic [7:0] c, input logic s);
        return s ? cwtc_pkg::HI_BASE_MV + 13'(c) * cwtc_pkg::HI_STEP_MV
                 : cwtc_pkg::LO_BASE_MV + 13'(c) * cwtc_pkg::LO_STEP_MV;
    endfunction
    // Shadow copy of the five registers, used to work out the expected thresholds.
    always_comb begin
        sh_nxt = sh_r;
        if (!i_rstn) begin
            sh_nxt = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h04};
        end else if (i_reg_wr && i_reg_addr inside {[8'h21:8'h25]}) begin
            sh_nxt[3'(i_reg_addr - 8'h21)] = i_reg_wdata;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        sh_r <= sh_nxt;
    end
    assign ov_now = i_vmon_mv > to_mv(sh_r[0], i_range_scaling_bit);
    assign uv_now = i_vmon_mv < to_mv(i_fast_under_limit, i_range_scaling_bit);
    a_unmapped_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !($past(i_reg_addr) inside {[8'h21:8'h25]}) |-> o_reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    a_write_readback: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        i_reg_wr && i_reg_addr inside {[8'h21:8'h25]} ##1 i_reg_addr == $past(i_reg_addr)
        |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("written byte not read back");
    a_over_cause: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(o_fast_over_fault) |-> $past(ov_now, 2))
        else $error("fast over fault without overvoltage");
    a_over_release: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $fell(o_fast_over_fault) |-> !$past(ov_now, 2))
        else $error("fast over fault dropped during overvoltage");
    a_under_cause: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(o_fast_under_fault) |-> $past(uv_now, 2))
        else $error("fast under fault without undervoltage");
    a_over_timely: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (UNIT == 1 && ov_now && sh_r[3][7:4] == 4'h2) [*8] |-> o_fast_over_fault)
        else $error("fast over fault late for code two");
    a_cut_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_cut_invalid == (sh_r[4][2:0] inside {3'h0, 3'h1, 3'h7}))
        else $error("cutoff invalid flag wrong");
    a_slow_over_cause: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(o_slow_over_fault) |-> $past(o_slow_vmon_mv > to_mv(sh_r[2], i_range_scaling_bit)))
        else $error("slow over fault below threshold");
endmodule
bind cwtc_top cwtc_chk #(.P_DEB_MAX_CYC(P_DEB_MAX_CYC)) chk_u (.i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_range_scaling_bit(i_range_scaling_bit),
    .i_fast_under_limit(i_fast_under_limit), .i_vmon_mv(i_vmon_mv),
    .o_slow_vmon_mv(o_slow_vmon_mv), .o_fast_over_fault(o_fast_over_fault),
    .o_fast_under_fault(o_fast_under_fault), .o_slow_over_fault(o_slow_over_fault),
    .o_slow_under_fault(o_slow_under_fault), .o_cut_invalid(o_cut_invalid));

// ---- sim/cwtc_host.sv ----
// Host model that programs the bank through its register port.
`timescale 1ns/1ns
module cwtc_host (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_reg_rdata,
    output logic o_reg_wr,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    // Codes are the caller's choice; only the cutoff sweep hands in invalid ones (0, 1 and 7).
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b0;
        o_reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_reg_addr <= a;
        @(posedge i_ref_clk);
        #1;
        d = i_reg_rdata;
    endtask
endmodule

// ---- sim/tb_cwtc_top.sv ----
// Self-checking bench for the channel 1 threshold bank.
`timescale 1ns/1ns
module tb_cwtc_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wr;
    logic scale = 1'b0;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] ulim = 8'h00;
    logic [12:0] vmon = 13'h012C;
    logic [12:0] slow_mv;
    logic fov, fuv, sov, suv, cut_inv;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    cwtc_top #(.P_DEB_MAX_CYC(1024)) dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_reg_wr(wr),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_range_scaling_bit(scale),
        .i_fast_under_limit(ulim), .i_vmon_mv(vmon), .o_slow_vmon_mv(slow_mv),
        .o_fast_over_fault(fov), .o_fast_under_fault(fuv), .o_slow_over_fault(sov),
        .o_slow_under_fault(suv), .o_cut_invalid(cut_inv));
    cwtc_host host_u (.i_ref_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_addr(addr),
        .o_reg_wdata(wdata));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic wait_flt(input bit uv, input logic lvl, output int n);
        n = 0;
        #1;
        while ((uv ? fuv : fov) !== lvl && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask
    task automatic t_regs;
        logic [7:0] d;
        logic [7:0] rst_v [5] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h04};
        for (int i = 0; i < 5; i++) begin
            host_u.rd(8'h21 + 8'(i), d);
            check("reset value", 16'(d), 16'(rst_v[i]));
        end
        for (int i = 0; i < 5; i++) begin
            host_u.wr(8'h21 + 8'(i), 8'h5A + 8'(i));
            host_u.rd(8'h21 + 8'(i), d);
            check("readback", 16'(d), 16'(8'h5A + 8'(i)));
        end
        host_u.wr(8'h20, 8'h77);
        host_u.wr(8'h26, 8'h77);
        host_u.rd(8'h20, d);
        check("unmapped low", 16'(d), 16'h0000);
        host_u.rd(8'h26, d);
        check("unmapped high", 16'(d), 16'h0000);
    endtask
    task automatic t_fast_over;
        int n;
        int nn;
        logic [3:0] code [4] = '{4'h2, 4'h3, 4'hA, 4'hC};
        host_u.wr(8'h21, 8'h40);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            scale <= 1'(i % 2);
            vmon <= 13'h012C;
            wait_flt(1'b0, 1'b0, n);
            host_u.wr(8'h24, {code[i], 4'h2});
            nn = 1 << ((code[i] > 4'hA) ? 10 : int'(code[i]));
            @(posedge clk);
            vmon <= ((i % 2) == 1) ? 13'h0821 : 13'h0209;
            wait_flt(1'b0, 1'b1, n);
            check("over set time", 16'(n >= nn + 1 && n <= nn + 3), 16'h0001);
            @(posedge clk);
            vmon <= ((i % 2) == 1) ? 13'h0820 : 13'h0208;
            wait_flt(1'b0, 1'b0, n);
            check("over clear time", 16'(n >= nn + 1 && n <= nn + 3), 16'h0001);
        end
    endtask
    task automatic t_fast_under;
        int n;
        @(posedge clk);
        scale <= 1'b0;
        vmon <= 13'h012C;
        host_u.wr(8'h24, 8'h23);
        @(posedge clk);
        ulim <= 8'h20;
        wait_flt(1'b1, 1'b1, n);
        check("under set time", 16'(n >= 9 && n <= 11), 16'h0001);
        @(posedge clk);
        vmon <= 13'h0168;
        wait_flt(1'b1, 1'b0, n);
        check("under clear time", 16'(n >= 9 && n <= 11), 16'h0001);
    endtask
    task automatic t_slow;
        logic [7:0] d;
        int n;
        for (int c = 0; c < 8; c++) begin
            host_u.wr(8'h25, {5'h15, 3'(c)});
            host_u.rd(8'h25, d);
            check("cutoff readback", 16'(d), 16'({5'h15, 3'(c)}));
            check("cutoff invalid", 16'(cut_inv), 16'(c == 0 || c == 1 || c == 7));
        end
        host_u.wr(8'h25, 8'h06);
        host_u.wr(8'h23, 8'h40);
        @(posedge clk);
        vmon <= 13'h03E8;
        n = 0;
        while (sov !== 1'b1 && n < 8000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("slow over fault", 16'(sov), 16'h0001);
        check("slow level", 16'(slow_mv > 13'h0208 && slow_mv <= 13'h03E8), 16'h0001);
        check("slow under fault", 16'(suv), 16'h0000);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_fast_over();
        t_fast_under();
        t_slow();
        print_verdict();
    end
endmodule
